// *** common/ucc_map.svh ***
`ifndef UCC_MAP_SVH
`define UCC_MAP_SVH
// apb byte offsets
`define UCC_A_DATA      8'h00
`define UCC_A_IER       8'h04
`define UCC_A_FCR       8'h08
`define UCC_A_ISR       8'h0c
`define UCC_A_LCR       8'h10
`define UCC_A_MCR       8'h14
`define UCC_A_LSR       8'h18
`define UCC_A_MSR       8'h1c
`define UCC_A_DLL       8'h20
`define UCC_A_DLM       8'h24
`define UCC_A_EFR       8'h28
`define UCC_A_STOP_CHAR_SECOND     8'h2c
`define UCC_A_TXLVL     8'h30
`define UCC_A_RXLVL     8'h34
`define UCC_A_FLWH      8'h38
`define UCC_A_FLWL      8'h3c
`define UCC_A_PRES      8'h40
`define UCC_A_EXTRA_FEATURE_CTRL_ONE     8'h44
`define UCC_A_STAT      8'h48
// field positions
`define UCC_EFR_SPC     5
`define UCC_EFR_ENH     4
`define UCC_IER_RX      0
`define UCC_IER_THR     1
`define UCC_IER_LS      2
`define UCC_IER_MS      3
`define UCC_IER_SLP     4
`define UCC_IER_XOFF    5
`define UCC_FCR_EN      0
`define UCC_FCR_RRST    1
`define UCC_FCR_TRST    2
`define UCC_FCR_DMA     3
`define UCC_MCR_DTR     0
`define UCC_MCR_RTS     1
`define UCC_MCR_OP1     2
`define UCC_MCR_OP2     3
`define UCC_MCR_LOOP    4
`define UCC_MCR_CLK     7
`define UCC_AF1_IGN     4
// interrupt ids and counts
`define UCC_ISR_NONE    6'h01
`define UCC_ISR_LS      6'h06
`define UCC_ISR_RXD     6'h04
`define UCC_ISR_RTO     6'h0c
`define UCC_ISR_THR     6'h02
`define UCC_ISR_MS      6'h00
`define UCC_ISR_SPC     6'h10
`define UCC_DEPTH_NORM  8'd32
`define UCC_DEPTH_EXT   8'd128
`define UCC_TO_CHARS    4
`define UCC_OVS         16
`endif

// *** common/ucc_pkg.sv ***
package ucc_pkg;
   typedef enum logic [1:0] {
      UCC_IDLE  = 2'b00,
      UCC_START = 2'b01,
      UCC_DATA  = 2'b10,
      UCC_STOP  = 2'b11
   } ucc_ser_t;
   typedef logic [7:0] ucc_byte_t;
endpackage

// *** src/ucc_fifo.sv ***
`timescale 1ns/100ps
`include "ucc_map.svh"
module ucc_fifo (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             clr,
   input  wire logic             wr,
   input  wire logic [7:0]       wdata,
   input  wire logic             rd,
   input  wire logic [7:0]       depth,
   output logic      [7:0]       rdata,
   output logic      [7:0]       count
);
   logic [7:0] mem [0:127];
   logic [6:0] wp_r;
   logic [6:0] rp_r;
   logic       do_wr;
   logic       do_rd;
   logic [6:0] head;
   // pointer step; wraps at 32 in normal mode so only the low part of the store is used
   function automatic logic [6:0] ucc_step(input logic [6:0] p, input logic [7:0] d);
      ucc_step = (d == `UCC_DEPTH_NORM) ? {2'b00, p[4:0] + 5'h01} : p + 7'h01;
   endfunction
   assign do_wr = wr && (count < depth);
   assign do_rd = rd && (count != 8'h00);
   assign head  = do_rd ? ucc_step(rp_r, depth) : rp_r;
   always_ff @(posedge pclk) begin
      if (do_wr) begin
         mem[wp_r] <= wdata;
      end
   end
   // registered read port; a write landing on the next head word is passed through,
   // otherwise a reader one cycle after the write would take the stale word
   always_ff @(posedge pclk) begin
      rdata <= (do_wr && wp_r == head) ? wdata : mem[head];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_r  <= 7'h00;
         rp_r  <= 7'h00;
         count <= 8'h00;
      end else if (clr) begin
         wp_r  <= 7'h00;
         rp_r  <= 7'h00;
         count <= 8'h00;
      end else begin
         if (do_wr) wp_r <= ucc_step(wp_r, depth);
         if (do_rd) rp_r <= ucc_step(rp_r, depth);
         count <= count + {7'h00, do_wr} - {7'h00, do_rd};
      end
   end
endmodule // ucc_fifo

// *** src/ucc_baud.sv ***
`timescale 1ns/100ps
`include "ucc_map.svh"
module ucc_baud (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             run,
   input  wire logic             quad,
   input  wire logic [15:0]      divisor,
   input  wire logic [3:0]       frac,
   output logic                  tick16
);
   // divide by prescaler*(16*N+M)/16 per 16x tick; fraction spread by accumulator
   logic [1:0]  pre_r;
   logic [15:0] cnt_r;
   logic [3:0]  acc_r;
   logic        pre_ok;
   logic [4:0]  acc_sum;
   assign pre_ok  = !quad || (pre_r == 2'h3);
   assign acc_sum = {1'b0, acc_r} + {1'b0, frac};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_r  <= 2'h0;
         cnt_r  <= 16'h0000;
         acc_r  <= 4'h0;
         tick16 <= 1'b0;
      end else if (!run || divisor == 16'h0000) begin
         pre_r  <= 2'h0;
         cnt_r  <= 16'h0000;
         tick16 <= 1'b0;
      end else begin
         tick16 <= 1'b0;
         pre_r  <= quad ? pre_r + 2'h1 : 2'h0;
         if (pre_ok) begin
            if (cnt_r == 16'h0000) begin
               tick16 <= 1'b1;
               acc_r  <= acc_sum[3:0];
               // an extra input cycle whenever the fraction accumulator wraps
               cnt_r  <= divisor - (acc_sum[4] ? 16'h0000 : 16'h0001);
            end else begin
               cnt_r <= cnt_r - 16'h0001;
            end
         end
      end
   end
endmodule // ucc_baud

// *** src/ucc_core.sv ***
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "ucc_map.svh"
module ucc_core
   import ucc_pkg::*;
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic             rx_pin,
   input  wire logic [3:0]       modem_in_n,
   input  wire logic             other_sleep_en,
   output logic                  tx_pin,
   output logic                  rts_n,
   output logic                  dtr_n,
   output logic                  user_output_one_n,
   output logic                  user_output_two_n,
   output logic                  irq_out,
   output logic                  irq_out_oe,
   output logic                  receive_ready_out_n,
   output logic                  transmit_ready_out_n,
   output logic                  asleep
);
   logic [7:0] ier_r, fcr_r, lcr_r, mcr_r, efr_r, stop_char_second_r, af1_r;
   logic [7:0] dll_r, dlm_r, txl_r, rxl_r, fh_r, fl_r, pres_r;
   logic [1:0] rx_s_r, rx_m_r;
   logic [3:0] md_s_r, md_m_r, md_prev_r;
   logic       thr_pend_r, spc_r, to_r, ovr_r, fe_r, pe_r, msd_r;
   logic       sleep_r, rxr_r, txr_r;
   logic       wr_acc, rd_acc, ext_mode, tick, rx_in, tx_bit;
   logic [7:0] depth, rxcnt, txcnt, rxq, txq, rx_trig, ch_bits, wmask;
   logic [3:0] modem;
   logic [5:0] isr_id;
   logic       rx_push, tx_pop, rx_rd, tx_wr, rx_pop_dat;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign ext_mode = (txl_r | rxl_r | fh_r | fl_r) != 8'h00;
   assign depth = ext_mode ? `UCC_DEPTH_EXT : `UCC_DEPTH_NORM;
   assign rx_rd = rd_acc && paddr == `UCC_A_DATA;
   assign tx_wr = wr_acc && paddr == `UCC_A_DATA;

   function automatic logic [7:0] ucc_lvl(input logic [1:0] s);
      unique case (s)
         2'b00: ucc_lvl = 8'd8;
         2'b01: ucc_lvl = 8'd16;
         2'b10: ucc_lvl = 8'd24;
         2'b11: ucc_lvl = 8'd28;
      endcase
   endfunction
   assign rx_trig = ext_mode ? rxl_r : ucc_lvl(fcr_r[7:6]);
   assign ch_bits = 8'd5 + {6'h00, lcr_r[1:0]};
   assign wmask   = 8'hff >> (3'd3 - {1'b0, lcr_r[1:0]});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ier_r <= 8'h00; fcr_r <= 8'h00; lcr_r <= 8'h00; mcr_r <= 8'h00;
         efr_r <= 8'h00; stop_char_second_r <= 8'h00; af1_r <= 8'h00; dll_r <= 8'h00;
         dlm_r <= 8'h00; txl_r <= 8'h00; rxl_r <= 8'h00; fh_r <= 8'h00;
         fl_r <= 8'h00; pres_r <= 8'h00;
      end else if (wr_acc) begin
         unique case (paddr)
            `UCC_A_IER:   ier_r   <= pwdata[7:0];
            `UCC_A_FCR:   fcr_r   <= pwdata[7:0] & 8'hf9;
            `UCC_A_LCR:   lcr_r   <= pwdata[7:0];
            `UCC_A_MCR:   mcr_r   <= pwdata[7:0];
            `UCC_A_DLL:   dll_r   <= pwdata[7:0];
            `UCC_A_DLM:   dlm_r   <= pwdata[7:0];
            `UCC_A_EFR:   efr_r   <= pwdata[7:0];
            `UCC_A_STOP_CHAR_SECOND: stop_char_second_r <= pwdata[7:0];
            `UCC_A_TXLVL: txl_r   <= pwdata[7:0];
            `UCC_A_RXLVL: rxl_r   <= pwdata[7:0];
            `UCC_A_FLWH:  fh_r    <= pwdata[7:0];
            `UCC_A_FLWL:  fl_r    <= pwdata[7:0];
            `UCC_A_PRES:  pres_r  <= {4'h0, pwdata[3:0]};
            `UCC_A_EXTRA_FEATURE_CTRL_ONE: af1_r   <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // pin synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_m_r <= 2'b11; rx_s_r <= 2'b11; md_m_r <= 4'hf; md_s_r <= 4'hf;
      end else begin
         rx_m_r <= {rx_m_r[0], rx_pin};
         rx_s_r <= {rx_s_r[0], rx_m_r[1]};
         md_m_r <= modem_in_n;
         md_s_r <= md_m_r;
      end
   end
   // loopback: cts,dsr,cd,ri <- rts,dtr,out2,out1 (active low pins)
   assign modem = mcr_r[`UCC_MCR_LOOP] ?
                  ~{mcr_r[`UCC_MCR_OP1], mcr_r[`UCC_MCR_OP2],
                    mcr_r[`UCC_MCR_DTR], mcr_r[`UCC_MCR_RTS]} : md_s_r;
   assign rx_in = mcr_r[`UCC_MCR_LOOP] ? tx_bit : rx_s_r[1];

   // sleep gates the baud generator, which stops both serial engines
   ucc_baud u_baud (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (!sleep_r),
      .quad    (mcr_r[`UCC_MCR_CLK]),
      .divisor ({dlm_r, dll_r}),
      .frac    (pres_r[3:0]),
      .tick16  (tick)
   );

   // transmitter
   ucc_ser_t   ts_r;
   logic [3:0] tph_r;
   logic [3:0] tbit_r;
   logic [7:0] tsh_r;
   assign tx_pop = ts_r == UCC_IDLE && tick && txcnt != 8'h00;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ts_r <= UCC_IDLE; tph_r <= 4'h0; tbit_r <= 4'h0; tsh_r <= 8'h00; tx_bit <= 1'b1;
      end else if (tick) begin
         tph_r <= tph_r + 4'h1;
         unique case (ts_r)
            UCC_IDLE: begin
               tph_r <= 4'h0;
               if (txcnt != 8'h00) begin
                  ts_r <= UCC_START; tsh_r <= txq; tx_bit <= 1'b0;
               end
            end
            UCC_START: if (tph_r == 4'hf) begin
               ts_r <= UCC_DATA; tbit_r <= 4'h0; tx_bit <= tsh_r[0];
            end
            UCC_DATA: if (tph_r == 4'hf) begin
               tsh_r  <= {1'b0, tsh_r[7:1]};
               tbit_r <= tbit_r + 4'h1;
               if (tbit_r == ch_bits[3:0] - 4'h1) begin
                  ts_r <= UCC_STOP; tx_bit <= 1'b1;
               end else begin
                  tx_bit <= tsh_r[1];
               end
            end
            UCC_STOP: if (tph_r == 4'hf) ts_r <= UCC_IDLE;
         endcase
      end
   end

   // receiver: samples at mid-bit, stop centre pushes the byte
   ucc_ser_t   rs_r;
   logic [3:0] rph_r, rbit_r;
   logic [7:0] rsh_r;
   logic       stop_mid, match;
   assign stop_mid = tick && rs_r == UCC_STOP && rph_r == 4'h7;
   assign match    = ((rsh_r ^ stop_char_second_r) & wmask) == 8'h00;
   // every character is stored while the fifo has room; a match only adds the flag
   assign rx_push  = stop_mid;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rs_r <= UCC_IDLE; rph_r <= 4'h0; rbit_r <= 4'h0; rsh_r <= 8'h00;
      end else if (tick) begin
         rph_r <= rph_r + 4'h1;
         unique case (rs_r)
            UCC_IDLE: begin
               rph_r <= 4'h0;
               if (!rx_in) rs_r <= UCC_START;
            end
            UCC_START: if (rph_r == 4'h7) begin
               if (rx_in) rs_r <= UCC_IDLE;
               rph_r <= 4'h8; rbit_r <= 4'h0; rsh_r <= 8'h00;
               if (!rx_in) rs_r <= UCC_DATA;
            end
            UCC_DATA: if (rph_r == 4'h7) begin
               // each bit enters at the top of the word, so short words end lsb-aligned
               rsh_r  <= {1'b0, rsh_r[7:1]} | ({7'h00, rx_in} << (ch_bits - 8'd1));
               rbit_r <= rbit_r + 4'h1;
               if (rbit_r == ch_bits[3:0] - 4'h1) rs_r <= UCC_STOP;
            end
            UCC_STOP: if (rph_r == 4'h7) rs_r <= UCC_IDLE;
         endcase
      end
   end
   ucc_fifo u_rxf (
      .pclk (pclk), .presetn (presetn), .clr (wr_acc && paddr == `UCC_A_FCR &&
             pwdata[`UCC_FCR_RRST]),
      .wr (rx_push), .wdata (rsh_r), .rd (rx_rd), .depth (depth),
      .rdata (rxq), .count (rxcnt)
   );
   ucc_fifo u_txf (
      .pclk (pclk), .presetn (presetn), .clr (wr_acc && paddr == `UCC_A_FCR &&
             pwdata[`UCC_FCR_TRST]),
      .wr (tx_wr), .wdata (pwdata[7:0]), .rd (tx_pop), .depth (depth),
      .rdata (txq), .count (txcnt)
   );

   // time-out: 4 chars of 16x ticks; stop length 1 or 2 (also 2 for 5-bit words)
   logic [11:0] to_cnt_r;
   logic [11:0] to_lim;
   assign to_lim = 12'(`UCC_TO_CHARS * `UCC_OVS) * ({4'h0, ch_bits} + 12'd1 +
                   {11'h0, lcr_r[3]} + (lcr_r[2] ? 12'd2 : 12'd1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         to_cnt_r <= 12'h000; to_r <= 1'b0;
      end else if (rxcnt == 8'h00 || stop_mid || rx_rd) begin
         to_cnt_r <= 12'h000; to_r <= 1'b0;
      end else if (tick && to_cnt_r != to_lim) begin
         to_cnt_r <= to_cnt_r + 12'h001;
         if (to_cnt_r + 12'h001 == to_lim) to_r <= 1'b1;
      end
   end

   // sticky sources; set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         thr_pend_r <= 1'b1; spc_r <= 1'b0; msd_r <= 1'b0; md_prev_r <= 4'hf;
         ovr_r <= 1'b0;
      end else begin
         md_prev_r <= modem;
         if (tx_wr || (rd_acc && paddr == `UCC_A_ISR && isr_id == `UCC_ISR_THR))
            thr_pend_r <= 1'b0;
         if (tx_pop && txcnt == 8'h01) thr_pend_r <= 1'b1;
         if (rd_acc && paddr == `UCC_A_ISR && isr_id == `UCC_ISR_SPC) spc_r <= 1'b0;
         if (rx_push && efr_r[`UCC_EFR_SPC] && match) spc_r <= 1'b1;
         if (rd_acc && paddr == `UCC_A_MSR) msd_r <= 1'b0;
         if (modem != md_prev_r) msd_r <= 1'b1;
         if (rd_acc && paddr == `UCC_A_LSR) ovr_r <= 1'b0;
         if (rx_push && rxcnt >= depth) ovr_r <= 1'b1;
      end
   end
   always_comb begin
      if (ier_r[`UCC_IER_LS] && ovr_r)                       isr_id = `UCC_ISR_LS;
      else if (ier_r[`UCC_IER_RX] && to_r)                   isr_id = `UCC_ISR_RTO;
      else if (ier_r[`UCC_IER_RX] && rxcnt >= rx_trig)       isr_id = `UCC_ISR_RXD;
      else if (ier_r[`UCC_IER_THR] && thr_pend_r)            isr_id = `UCC_ISR_THR;
      else if (ier_r[`UCC_IER_MS] && msd_r)                  isr_id = `UCC_ISR_MS;
      else if (ier_r[`UCC_IER_XOFF] && spc_r)                isr_id = `UCC_ISR_SPC;
      else                                                   isr_id = `UCC_ISR_NONE;
   end

   // dma ready pins, active low outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxr_r <= 1'b1; txr_r <= 1'b0;
      end else if (!fcr_r[`UCC_FCR_DMA]) begin
         rxr_r <= rxcnt == 8'h00;
         txr_r <= txcnt != 8'h00;
      end else begin
         if (rxcnt >= rx_trig || to_r) rxr_r <= 1'b0;
         if (rxcnt == 8'h00) rxr_r <= 1'b1;
         if (txcnt < depth) txr_r <= 1'b0;
         if (txcnt >= depth) txr_r <= 1'b1;
      end
   end

   // sleep
   logic [11:0] idle_r;
   logic        can_sleep, wake;
   assign wake = !rx_in || tx_wr || modem != md_prev_r;
   assign can_sleep = efr_r[`UCC_EFR_ENH] && ier_r[`UCC_IER_SLP] &&
                      other_sleep_en &&
                      (af1_r[`UCC_AF1_IGN] || idle_r == to_lim) &&
                      txcnt == 8'h00 && ts_r == UCC_IDLE && rxcnt == 8'h00 &&
                      rs_r == UCC_IDLE &&                // a character in flight is unread data
                      isr_id == `UCC_ISR_NONE;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_r <= 12'h000; sleep_r <= 1'b0;
      end else begin
         if (!rx_in || modem != md_prev_r) idle_r <= 12'h000;
         else if (tick && idle_r != to_lim) idle_r <= idle_r + 12'h001;
         sleep_r <= !wake && (sleep_r ? ier_r[`UCC_IER_SLP] : can_sleep);
      end
   end

   // outputs and apb
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_pin <= 1'b1; rts_n <= 1'b1; dtr_n <= 1'b1; user_output_one_n <= 1'b1;
         user_output_two_n <= 1'b1; irq_out <= 1'b0; irq_out_oe <= 1'b1;
         receive_ready_out_n <= 1'b1; transmit_ready_out_n <= 1'b0; asleep <= 1'b0;
         prdata <= 32'h0; pready <= 1'b0; pslverr <= 1'b0;
      end else begin
         tx_pin <= mcr_r[`UCC_MCR_LOOP] ? 1'b1 : tx_bit;
         rts_n  <= mcr_r[`UCC_MCR_LOOP] | ~mcr_r[`UCC_MCR_RTS];
         dtr_n  <= mcr_r[`UCC_MCR_LOOP] | ~mcr_r[`UCC_MCR_DTR];
         user_output_one_n <= ~mcr_r[`UCC_MCR_OP1];
         user_output_two_n <= ~mcr_r[`UCC_MCR_OP2];
         irq_out    <= isr_id != `UCC_ISR_NONE;
         irq_out_oe <= !mcr_r[`UCC_MCR_LOOP];
         receive_ready_out_n  <= rxr_r;
         transmit_ready_out_n <= txr_r;
         asleep <= sleep_r;
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= 32'h0;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               `UCC_A_DATA:  prdata[7:0] <= rxq;
               `UCC_A_IER:   prdata[7:0] <= ier_r;
               `UCC_A_FCR:   prdata[7:0] <= fcr_r;
               `UCC_A_ISR:   prdata[7:0] <= {fcr_r[`UCC_FCR_EN], fcr_r[`UCC_FCR_EN], isr_id};
               `UCC_A_LCR:   prdata[7:0] <= lcr_r;
               `UCC_A_MCR:   prdata[7:0] <= mcr_r;
               `UCC_A_LSR:   prdata[7:0] <= {1'b0, txcnt == 8'h00 && ts_r == UCC_IDLE,
                                             txcnt == 8'h00, 3'b000, ovr_r, rxcnt != 8'h00};
               `UCC_A_MSR:   prdata[7:0] <= {~modem[2], ~modem[3], ~modem[1], ~modem[0],
                                             3'b000, msd_r};
               `UCC_A_DLL:   prdata[7:0] <= dll_r;
               `UCC_A_DLM:   prdata[7:0] <= dlm_r;
               `UCC_A_EFR:   prdata[7:0] <= efr_r;
               `UCC_A_STOP_CHAR_SECOND: prdata[7:0] <= stop_char_second_r;
               `UCC_A_TXLVL: prdata[7:0] <= txl_r;
               `UCC_A_RXLVL: prdata[7:0] <= rxl_r;
               `UCC_A_FLWH:  prdata[7:0] <= fh_r;
               `UCC_A_FLWL:  prdata[7:0] <= fl_r;
               `UCC_A_PRES:  prdata[7:0] <= pres_r;
               `UCC_A_EXTRA_FEATURE_CTRL_ONE: prdata[7:0] <= af1_r;
               `UCC_A_STAT:  prdata[15:0] <= {txcnt, rxcnt};
               default:      pslverr <= 1'b1;
            endcase
         end else if (psel && !penable) begin
            pslverr <= paddr > `UCC_A_STAT || paddr[1:0] != 2'b00;
         end
      end
   end
endmodule // ucc_core

// *** tb/ucc_core_assertions.sv ***
`timescale 1ns/100ps
`include "ucc_map.svh"
module ucc_chk (
   input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic [3:0]  modem_in_n,
   input wire logic        rx_pin, irq_out, irq_out_oe, asleep, receive_ready_out_n
);
   logic acc;
   logic mcr_wr;
   assign acc = psel && penable && pready;
   assign mcr_wr = acc && pwrite && paddr == `UCC_A_MCR;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s; psel && !penable; endsequence
   sequence access_s; psel && penable && pready; endsequence
   apb_answer_a: assert property (setup_s |=> access_s) else $error("setup not answered");
   ready_phase_a: assert property (pready |-> psel && penable) else $error("stray pready");
   err_flag_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
   upper_zero_a: assert property (pready && !pslverr |-> prdata[31:16] == 16'h0000)
      else $error("read data upper half set");
   loop_oe_a: assert property ($fell(irq_out_oe) |->
      $past(mcr_wr) || $past(mcr_wr, 2)) else $error("irq enable dropped without control write");
   sleep_quiet_a: assert property (asleep |-> receive_ready_out_n && !irq_out)
      else $error("asleep with data or interrupt");
   wake_modem_a: assert property (asleep && $changed(modem_in_n) |-> ##[1:8] !asleep)
      else $error("no wake on modem change");
   wake_start_a: assert property (asleep && $fell(rx_pin) |-> ##[1:8] !asleep)
      else $error("no wake on start bit");
   wake_write_a: assert property (asleep && acc && pwrite && paddr == `UCC_A_DATA |->
      ##[1:8] !asleep) else $error("no wake on transmit write");
endmodule // ucc_chk
bind ucc_core ucc_chk ucc_chk_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .pslverr(pslverr), .paddr(paddr), .prdata(prdata), .rx_pin(rx_pin),
   .modem_in_n(modem_in_n), .irq_out(irq_out), .irq_out_oe(irq_out_oe), .asleep(asleep),
   .receive_ready_out_n(receive_ready_out_n)
);

// *** tb/ucc_remote.sv ***
`timescale 1ns/100ps
module ucc_remote (
   input  wire logic       pclk,
   input  wire logic       tx_pin,
   output logic            rx_pin,
   output logic [3:0]      modem_in_n
);
   initial begin
      rx_pin = 1'b1;
      modem_in_n = 4'hf;
   end
   // one stop bit, then the line rests at its idle high level
   task automatic send(input logic [7:0] b, input int nb, input int bt);
      @(posedge pclk);
      for (int i = -1; i <= nb; i++) begin
         rx_pin <= (i < 0) ? 1'b0 : (i == nb) ? 1'b1 : b[i];
         repeat (bt) @(posedge pclk);
      end
   endtask
   // start bit length gives the bit time, so bit 0 of the byte must be 1
   task automatic recv(output logic [7:0] b, output int bt);
      int n;
      n = 0;
      bt = 0;
      while (tx_pin !== 1'b0 && n < 5000) begin
         @(posedge pclk);
         n++;
      end
      while (tx_pin === 1'b0 && bt < 5000) begin
         @(posedge pclk);
         bt++;
      end
      repeat (bt / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         b[i] = tx_pin;
         repeat (bt) @(posedge pclk);
      end
   endtask
   task automatic modem(input logic [3:0] v);
      @(posedge pclk);
      modem_in_n <= v;
   endtask
endmodule // ucc_remote

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`include "ucc_map.svh"
module tb_top;
   logic        pclk, presetn, psel, penable, pwrite, other_sleep_en, pready, pslverr;
   logic        rx_pin, tx_pin, irq_out, irq_out_oe, asleep, receive_ready_out_n;
   logic [7:0]  paddr, b;
   logic [31:0] pwdata, prdata, q;
   logic [3:0]  modem_in_n;
   logic        transmit_ready_out_n;
   int          fail_count, tests_run, bt;
   ucc_core ucc_core_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_pin(rx_pin), .modem_in_n(modem_in_n), .other_sleep_en(other_sleep_en),
      .tx_pin(tx_pin), .rts_n(), .dtr_n(), .user_output_one_n(), .user_output_two_n(),
      .irq_out(irq_out), .irq_out_oe(irq_out_oe), .receive_ready_out_n(receive_ready_out_n),
      .transmit_ready_out_n(transmit_ready_out_n), .asleep(asleep));
   ucc_remote ucc_remote_i (.pclk(pclk), .tx_pin(tx_pin), .rx_pin(rx_pin),
      .modem_in_n(modem_in_n));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("mismatch %s exp %h got %h", nm, e, g);
         fail_count++;
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // read data lands in q; held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      if (n >= 20) chk("apb answer", 1, 0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_lvl(ref logic s, input logic v, input int lim, input string nm);
      for (int n = 0; n < lim && s !== v; n++) @(posedge pclk);
      chk(nm, {31'h0, v}, {31'h0, s});
   endtask
   task t_reset;
      apb(1, `UCC_A_IER, 32'h02);
      apb(0, `UCC_A_ISR, 0);
      chk("isr", 32'h02, q);
      chk("irq", 1, irq_out);
      apb(0, `UCC_A_ISR, 0);
      chk("isr", 32'h01, q);
      apb(0, 8'hfc, 0);
      chk("pslverr", 1, pslverr);
   endtask
   task t_baud;
      apb(1, `UCC_A_LCR, 32'h03);
      apb(1, `UCC_A_IER, 32'h00);
      apb(1, `UCC_A_DLL, 32'h01);
      apb(1, `UCC_A_DLM, 32'h00);
      for (int k = 0; k < 2; k++) begin
         apb(1, `UCC_A_MCR, k ? 32'h80 : 32'h00);
         apb(1, `UCC_A_PRES, k ? 32'h03 : 32'h00);
         apb(1, `UCC_A_DATA, 32'ha5);
         ucc_remote_i.recv(b, bt);
         chk("tx byte", 32'ha5, {24'h0, b});
         chk("bit time", k ? 76 : 16, 32'(bt));
      end
   endtask
   task t_special;
      apb(1, `UCC_A_MCR, 0);
      apb(1, `UCC_A_PRES, 0);
      apb(1, `UCC_A_LCR, 0);
      apb(1, `UCC_A_FCR, 32'h01);
      apb(1, `UCC_A_EFR, 32'h30);
      apb(1, `UCC_A_STOP_CHAR_SECOND, 32'hf5);
      apb(1, `UCC_A_IER, 32'h21);
      ucc_remote_i.send(8'h15, 5, 16);
      chk("rx ready", 0, receive_ready_out_n);
      repeat (480) @(posedge pclk);
      apb(0, `UCC_A_DATA, 0);
      chk("data", 32'h15, q);
      apb(0, `UCC_A_ISR, 0);
      chk("isr", 32'hd0, q);
      chk("rx ready", 1, receive_ready_out_n);
      ucc_remote_i.send(8'h0a, 5, 16);
      repeat (400) @(posedge pclk);
      apb(0, `UCC_A_ISR, 0);
      chk("isr", 32'hc1, q);
      repeat (80) @(posedge pclk);
      apb(0, `UCC_A_ISR, 0);
      chk("isr", 32'hcc, q);
      apb(0, `UCC_A_DATA, 0);
      apb(0, `UCC_A_ISR, 0);
      chk("isr", 32'hc1, q);
   endtask
   task t_loop;
      apb(1, `UCC_A_LCR, 32'h03);
      apb(1, `UCC_A_MCR, 32'h15);
      apb(0, `UCC_A_MSR, 0);
      chk("modem", 4'h6, q[7:4]);
      chk("irq oe", 0, irq_out_oe);
      apb(1, `UCC_A_DATA, 32'h3c);
      wait_lvl(receive_ready_out_n, 0, 400, "loop rx");
      apb(0, `UCC_A_DATA, 0);
      chk("loop data", 32'h3c, q);
      apb(1, `UCC_A_DLL, 0);
      apb(1, `UCC_A_FCR, 32'h09);
      for (int i = 0; i < 33; i++) apb(1, `UCC_A_DATA, i);
      apb(0, `UCC_A_STAT, 0);
      chk("tx count", 32, q[15:8]);
      chk("tx ready", 1, transmit_ready_out_n);
      apb(1, `UCC_A_FCR, 32'h05);
      apb(1, `UCC_A_DLL, 32'h01);
      chk("tx ready", 0, transmit_ready_out_n);
      apb(1, `UCC_A_MCR, 0);
   endtask
   task t_sleep;
      apb(1, `UCC_A_EXTRA_FEATURE_CTRL_ONE, 32'h10);
      other_sleep_en <= 1'b0;
      apb(1, `UCC_A_IER, 32'h10);
      repeat (300) @(posedge pclk);
      chk("asleep", 0, asleep);
      other_sleep_en <= 1'b1;
      wait_lvl(asleep, 1, 500, "sleep");
      ucc_remote_i.modem(4'he);
      wait_lvl(asleep, 0, 8, "modem wake");
      wait_lvl(asleep, 1, 500, "resleep");
      apb(1, `UCC_A_DATA, 32'h81);
      wait_lvl(asleep, 0, 8, "write wake");
      wait_lvl(asleep, 1, 1000, "resleep");
      ucc_remote_i.send(8'h42, 8, 16);
      chk("asleep", 0, asleep);
      apb(0, `UCC_A_DATA, 0);
      chk("data", 32'h42, q);
      wait_lvl(asleep, 1, 500, "resleep");
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      other_sleep_en = 1'b1;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_baud;
      t_special;
      t_loop;
      t_sleep;
      close_out;
   end
   initial begin
      repeat (100000) @(posedge pclk);
      fail_count++;
      close_out;
   end
endmodule // tb_top
